/* core/rpd_pkg.sv */
// shared constants and types for the reed pulse debounce and calibration
package rpd_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int RTC_KHZ        = 32;
    localparam int SAMPLE_US      = 250;
    localparam int RTC_PER_SAMPLE = SAMPLE_US * RTC_KHZ / 1000;
    localparam int TEST_US        = 750;
    localparam int SMP_PER_TEST   = TEST_US / SAMPLE_US;
    localparam int CAL_TESTS      = 28;

    localparam logic [4:0] LAST_CODE = 5'(CAL_TESTS - 1);
    localparam logic [1:0] LAST_SUB  = 2'(SMP_PER_TEST - 1);

    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_MODE  = 8'h04;
    localparam logic [7:0] ADDR_RISE  = 8'h08;
    localparam logic [7:0] ADDR_FALL  = 8'h0C;
    localparam logic [7:0] ADDR_PUCFG = 8'h10;
    localparam logic [7:0] ADDR_STS   = 8'h14;
    localparam logic [7:0] ADDR_MSK   = 8'h18;
    localparam logic [7:0] ADDR_STATE = 8'h1C;

    localparam int CTRL_START = 0;
    localparam int CTRL_SEL   = 1;
    localparam int PU_BUSY    = 5;
    localparam int PU_FAIL    = 6;
    localparam int STS_OPEN   = 0;
    localparam int STS_DONE   = 1;
    localparam int STS_FAIL   = 2;

    localparam logic [7:0] RISE_RST = 8'h04;
    localparam logic [7:0] FALL_RST = 8'h04;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    typedef enum logic {CAL_IDLE, CAL_TEST} rpd_cal_t;

    typedef struct packed {
        logic [7:0] cnt;
        logic       out;
    } rpd_int_t;

    typedef struct packed {
        logic        awvalid;
        logic [7:0]  awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [7:0]  araddr;
        logic        rready;
    } rpd_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } rpd_axi_rsp_t;

endpackage

/* core/rpd_top.sv */
// reed pulse debounce integrators, sampler and pull-up calibration engine
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - calibration tests only the input chosen by a software select bit
// - during calibration integrators ignore inputs and counters are held
// - at most 28 pull-up tests, each three sample periods long
// - calibration stops early at the first strength that succeeds
// - calibration fails when the selected input stays low throughout
// - chosen strength is written into the five-bit pull-up code field
// - one pull-up code drives both pulse inputs alike
// - a flag is set when the monitored switch opens
// - inputs are sampled only on ticks derived from the slow clock
// - sample period selectable from 250 us to 2 ms by mode register
// - integrators take sampled inputs and feed the counter outputs
// - output rises once accumulated high samples reach rise threshold
// - output falls once accumulated low samples reach fall threshold
// - samples accumulate, so a stray sample does not restart debounce
// - high level means switch open, low level means switch closed
module rpd_top
    import rpd_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire rpd_axi_req_t axi_req,
    output rpd_axi_rsp_t      axi_rsp,
    input  wire logic         pulse_input_a,
    input  wire logic         pulse_input_b,
    input  wire logic         slow_timebase_clock,
    output logic [4:0]        pullup_strength_code,
    output logic              counter_in_a,
    output logic              counter_in_b,
    output logic              count_hold,
    output logic              irq
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic         a_s1;
        logic         a_s2;
        logic         b_s1;
        logic         b_s2;
        logic         r_s1;
        logic         r_s2;
        logic         r_s3;
        logic [6:0]   div;
        logic         tick;
        logic         smp_a;
        logic         smp_b;
        rpd_int_t     int_a;
        rpd_int_t     int_b;
        rpd_cal_t     cal;
        logic [4:0]   idx;
        logic [1:0]   sub;
        logic [4:0]   code;
        logic         fail;
        logic         hold;
        logic         sel;
        logic [1:0]   rate;
        logic [7:0]   rise;
        logic [7:0]   fall;
        logic [2:0]   sts;
        logic [2:0]   msk;
        logic         irq;
        logic         awv;
        logic [7:0]   awa;
        logic         wv;
        logic [31:0]  wd;
        logic [3:0]   ws;
        rpd_axi_rsp_t rsp;
    } rpd_state_t;

    rpd_state_t st_q;
    rpd_state_t st_d;

    ////////////////////////////////////////////////////////////////////////
    // high sample counts toward flipping a low output and vice versa;
    // opposite samples decay the count instead of clearing it
    function automatic rpd_int_t integ(rpd_int_t s, logic smp,
                                       logic [7:0] rise, logic [7:0] fall);
        rpd_int_t r;
        r = s;
        if (smp != s.out) begin
            if (s.cnt != 8'hFF) begin
                r.cnt = s.cnt + 8'h01;
            end
            if (r.cnt >= (s.out ? fall : rise)) begin
                r.out = smp;
                r.cnt = 8'h00;
            end
        end else if (s.cnt != 8'h00) begin
            r.cnt = s.cnt - 8'h01;
        end
        return r;
    endfunction

    function automatic logic [31:0] rd_word(logic [7:0] a, rpd_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        case (a)
            ADDR_CTRL:  w[CTRL_SEL] = s.sel;
            ADDR_MODE:  w[1:0] = s.rate;
            ADDR_RISE:  w[7:0] = s.rise;
            ADDR_FALL:  w[7:0] = s.fall;
            ADDR_PUCFG: begin
                w[4:0] = s.code;
                w[PU_BUSY] = s.hold;
                w[PU_FAIL] = s.fail;
            end
            ADDR_STS:   w[2:0] = s.sts;
            ADDR_MSK:   w[2:0] = s.msk;
            ADDR_STATE: w[3:0] = {s.smp_b, s.smp_a,
                                  s.int_b.out, s.int_a.out};
            default:    w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    function automatic logic mapped(logic [7:0] a);
        return (a[7:5] == 3'h0) && (a[1:0] == 2'h0);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic       wr_go;
    logic       start;
    logic       new_a;
    logic       new_b;
    logic       sel_old;
    logic       sel_new;
    logic       open_ev;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [6:0] div_last;

    always_comb begin
        st_d    = st_q;
        ev      = 3'h0;
        clr     = 3'h0;
        start   = 1'b0;
        // first stage feeds only the second stage
        st_d.a_s1 = pulse_input_a;
        st_d.a_s2 = st_q.a_s1;
        st_d.b_s1 = pulse_input_b;
        st_d.b_s2 = st_q.b_s1;
        st_d.r_s1 = slow_timebase_clock;
        st_d.r_s2 = st_q.r_s1;
        st_d.r_s3 = st_q.r_s2;

        // sample tick every 8, 16, 32 or 64 slow clock edges
        div_last  = (7'(RTC_PER_SAMPLE) << st_q.rate) - 7'h01;
        st_d.tick = 1'b0;
        if (st_q.r_s2 && !st_q.r_s3) begin
            if (st_q.div >= div_last) begin
                st_d.div  = 7'h00;
                st_d.tick = 1'b1;
            end else begin
                st_d.div = st_q.div + 7'h01;
            end
        end

        // levels are latched only on the tick, high means open
        new_a   = st_q.tick ? st_q.a_s2 : st_q.smp_a;
        new_b   = st_q.tick ? st_q.b_s2 : st_q.smp_b;
        st_d.smp_a = new_a;
        st_d.smp_b = new_b;
        sel_old = st_q.sel ? st_q.smp_b : st_q.smp_a;
        sel_new = st_q.sel ? new_b : new_a;
        open_ev = st_q.tick && !sel_old && sel_new;
        ev[STS_OPEN] = open_ev;

        // integrators frozen while calibration drives the pull-ups
        if (st_q.tick && st_q.cal == CAL_IDLE) begin
            st_d.int_a = integ(st_q.int_a, new_a,
                               st_q.rise, st_q.fall);
            st_d.int_b = integ(st_q.int_b, new_b,
                               st_q.rise, st_q.fall);
        end

        ////////////////////////////////////////////////////////////////////
        // register bus, write side
        wr_go = st_q.awv && st_q.wv && !st_q.rsp.bvalid;
        if (axi_req.awvalid && st_q.rsp.awready) begin
            st_d.awv = 1'b1;
            st_d.awa = axi_req.awaddr;
        end
        if (axi_req.wvalid && st_q.rsp.wready) begin
            st_d.wv = 1'b1;
            st_d.wd = axi_req.wdata;
            st_d.ws = axi_req.wstrb;
        end
        if (st_q.rsp.bvalid && axi_req.bready) begin
            st_d.rsp.bvalid = 1'b0;
        end
        if (wr_go) begin
            st_d.awv = 1'b0;
            st_d.wv  = 1'b0;
            st_d.rsp.bvalid = 1'b1;
            st_d.rsp.bresp  = mapped(st_q.awa) ? RESP_OK : RESP_ERR;
            if (mapped(st_q.awa) && st_q.ws[0]) begin
                case (st_q.awa)
                    ADDR_CTRL: begin
                        start = st_q.wd[CTRL_START];
                        if (st_q.cal == CAL_IDLE) begin
                            st_d.sel = st_q.wd[CTRL_SEL];
                        end
                    end
                    ADDR_MODE: st_d.rate = st_q.wd[1:0];
                    ADDR_RISE: st_d.rise = st_q.wd[7:0];
                    ADDR_FALL: st_d.fall = st_q.wd[7:0];
                    ADDR_PUCFG: begin
                        if (st_q.cal == CAL_IDLE) begin
                            st_d.code = st_q.wd[4:0];
                        end
                    end
                    ADDR_STS:  clr = st_q.wd[2:0];
                    ADDR_MSK:  st_d.msk = st_q.wd[2:0];
                    default:   clr = 3'h0;
                endcase
            end
        end
        st_d.rsp.awready = !st_d.awv;
        st_d.rsp.wready  = !st_d.wv;

        // register bus, read side
        if (st_q.rsp.rvalid && axi_req.rready) begin
            st_d.rsp.rvalid = 1'b0;
        end
        if (axi_req.arvalid && st_q.rsp.arready) begin
            st_d.rsp.rvalid = 1'b1;
            st_d.rsp.rdata  = rd_word(axi_req.araddr, st_q);
            st_d.rsp.rresp  = mapped(axi_req.araddr) ? RESP_OK : RESP_ERR;
        end
        st_d.rsp.arready = !st_d.rsp.rvalid;

        ////////////////////////////////////////////////////////////////////
        // calibration: weakest code first, one test per three samples
        case (st_q.cal)
            CAL_IDLE: begin
                if (start) begin
                    st_d.cal  = CAL_TEST;
                    st_d.idx  = 5'h00;
                    st_d.sub  = 2'h0;
                    st_d.code = 5'h00;
                    st_d.fail = 1'b0;
                end
            end
            CAL_TEST: begin
                if (st_q.tick) begin
                    if (st_q.sub != LAST_SUB) begin
                        st_d.sub = st_q.sub + 2'h1;
                    end else if (sel_new) begin
                        // charged to high: keep this code
                        st_d.cal = CAL_IDLE;
                        st_d.code = st_q.idx;
                        ev[STS_DONE] = 1'b1;
                    end else if (st_q.idx == LAST_CODE) begin
                        st_d.cal  = CAL_IDLE;
                        st_d.fail = 1'b1;
                        ev[STS_DONE] = 1'b1;
                        ev[STS_FAIL] = 1'b1;
                    end else begin
                        st_d.idx  = st_q.idx + 5'h01;
                        st_d.code = st_q.idx + 5'h01;
                        st_d.sub  = 2'h0;
                    end
                end
            end
            default: st_d.cal = CAL_IDLE;
        endcase
        st_d.hold = (st_d.cal == CAL_TEST);

        // a new event beats a clear in the same cycle
        st_d.sts = (st_q.sts & ~clr) | ev;
        st_d.irq = |(st_d.sts & st_d.msk);
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st_q             <= '0;
            st_q.rise        <= RISE_RST;
            st_q.fall        <= FALL_RST;
            st_q.rsp.awready <= 1'b1;
            st_q.rsp.wready  <= 1'b1;
            st_q.rsp.arready <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // single code shared by both inputs
    assign pullup_strength_code = st_q.code;
    assign counter_in_a         = st_q.int_a.out;
    assign counter_in_b         = st_q.int_b.out;
    assign count_hold           = st_q.hold;
    assign irq                  = st_q.irq;
    assign axi_rsp              = st_q.rsp;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_cal_freeze: assert property (
        st_q.cal == CAL_TEST |=> $stable(st_q.int_a) && $stable(st_q.int_b))
        else $error("integrator moved during calibration");

    a_code_bound: assert property (
        st_q.hold |-> st_q.code <= 5'h1B && st_q.code == st_q.idx)
        else $error("pull-up code outside test range");

    a_early_stop: assert property (
        st_q.hold && st_q.tick && st_q.sub == 2'h2 &&
        (st_q.sel ? st_q.b_s2 : st_q.a_s2)
        |=> !st_q.hold && !st_q.fail && st_q.sts[STS_DONE])
        else $error("passing test did not end calibration");

    a_fail_last: assert property (
        $rose(st_q.fail) |-> $past(st_q.idx) == 5'h1B && !st_q.hold)
        else $error("failure flagged before last test");

    a_tick_sample: assert property (
        $changed(st_q.smp_a) || $changed(st_q.smp_b) |-> $past(st_q.tick))
        else $error("input sampled off tick");

    a_rise_high: assert property (
        $rose(st_q.int_a.out) |-> st_q.smp_a && st_q.int_a.cnt == 8'h00)
        else $error("output rose without high sample");

    a_fall_low: assert property (
        $fell(st_q.int_a.out) |-> !st_q.smp_a && st_q.int_a.cnt == 8'h00)
        else $error("output fell without low sample");

    a_open_flag: assert property (
        st_q.tick && !st_q.hold && st_q.sel == 1'b0 && !st_q.smp_a &&
        st_q.a_s2 |=> st_q.sts[STS_OPEN])
        else $error("switch opening not flagged");

    a_irq_level: assert property (
        (|(st_q.sts & st_q.msk)) |-> irq ##1 (irq || $past(wr_go)))
        else $error("interrupt missing for pending status");

    a_sel_locked: assert property (
        st_q.hold |=> $stable(st_q.sel))
        else $error("input select changed during calibration");

    a_hold_match: assert property (
        count_hold == (st_q.cal == CAL_TEST))
        else $error("count hold does not follow calibration");

    a_sub_limit: assert property (
        st_q.sub <= LAST_SUB)
        else $error("test sample counter past three samples");

    a_start_weak: assert property (
        $rose(st_q.hold) |-> st_q.code == 5'h00 && st_q.idx == 5'h00)
        else $error("calibration did not start at weakest code");

    a_fail_code: assert property (
        $rose(st_q.fail) |-> pullup_strength_code == LAST_CODE)
        else $error("failed calibration left wrong code");

    a_tick_single: assert property (
        st_q.tick |=> !st_q.tick)
        else $error("sample tick longer than one cycle");

    c_cal_pass: cover property (
        st_q.hold ##1 !st_q.hold && !st_q.fail);
    c_cal_fail: cover property ($rose(st_q.fail));
    c_deb_rise: cover property ($rose(st_q.int_a.out));
    c_irq_up:   cover property ($rose(irq));
    c_open_ev:  cover property ($rose(st_q.sts[STS_OPEN]));

endmodule

/* tb/rpd_reed_model.sv */
// reed switch pair on field wiring, each with a pull-up from the block
`timescale 1ns/1ps

module rpd_reed_model (
    input  wire logic [4:0] pullup_strength_code,
    input  wire logic       closed_a,
    input  wire logic       closed_b,
    input  wire logic [4:0] need_a,
    input  wire logic [4:0] need_b,
    output logic            pulse_input_a,
    output logic            pulse_input_b
);

    ////////////////////////////////////////////////////////////////////////
    // a closed switch shorts the line low; an open one only charges when
    // the shared pull-up beats the wiring load, else it reads low
    assign pulse_input_a = !closed_a
                           && (pullup_strength_code >= need_a);
    assign pulse_input_b = !closed_b
                           && (pullup_strength_code >= need_b);

endmodule

/* tb/tb_reed_pulse_debounce_calibration.sv */
// self-checking bench for the reed pulse debounce and calibration block
`timescale 1ns/1ps

module tb_reed_pulse_debounce_calibration;
    import rpd_pkg::*;

    logic         clk;
    logic         sys_rst;
    rpd_axi_req_t axi_req;
    rpd_axi_rsp_t axi_rsp;
    logic         pulse_input_a;
    logic         pulse_input_b;
    logic         slow_timebase_clock = 1'b0;
    logic [4:0]   pullup_strength_code;
    logic         counter_in_a;
    logic         counter_in_b;
    logic         count_hold;
    logic         irq;
    logic         closed_a;
    logic         closed_b;
    logic [4:0]   need_a;
    logic [4:0]   need_b;
    logic [1:0]   resp;
    logic [3:0]   mon;
    int           n_fail;
    int           cmp_count;
    int           cyc = 0;
    int           slow_div = 0;

    assign mon = {irq, count_hold, counter_in_b, counter_in_a};

    rpd_top uut (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .axi_req              (axi_req),
        .axi_rsp              (axi_rsp),
        .pulse_input_a        (pulse_input_a),
        .pulse_input_b        (pulse_input_b),
        .slow_timebase_clock  (slow_timebase_clock),
        .pullup_strength_code (pullup_strength_code),
        .counter_in_a         (counter_in_a),
        .counter_in_b         (counter_in_b),
        .count_hold           (count_hold),
        .irq                  (irq)
    );

    rpd_reed_model reeds (
        .pullup_strength_code (pullup_strength_code),
        .closed_a             (closed_a),
        .closed_b             (closed_b),
        .need_a               (need_a),
        .need_b               (need_b),
        .pulse_input_a        (pulse_input_a),
        .pulse_input_b        (pulse_input_b)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // slow clock of 10 clk period, so one 250 us tick is 80 clk
    always @(posedge clk) begin
        slow_div <= (slow_div == 4) ? 0 : slow_div + 1;
        if (slow_div == 4)
            slow_timebase_clock <= !slow_timebase_clock;
    end

    // ceiling well above the ~13k cycles the tests need
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_fail++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // bready and rready stay high for the whole run
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        axi_req.awvalid <= 1'b1;
        axi_req.awaddr  <= a;
        axi_req.wvalid  <= 1'b1;
        axi_req.wdata   <= d;
        axi_req.wstrb   <= 4'hF;
        forever begin
            @(posedge clk);
            if (axi_req.awvalid && axi_rsp.awready)
                axi_req.awvalid <= 1'b0;
            if (axi_req.wvalid && axi_rsp.wready)
                axi_req.wvalid <= 1'b0;
            if (axi_rsp.bvalid === 1'b1) begin
                resp = axi_rsp.bresp;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                      input string what);
        axi_req.arvalid <= 1'b1;
        axi_req.araddr  <= a;
        forever begin
            @(posedge clk);
            if (axi_req.arvalid && axi_rsp.arready)
                axi_req.arvalid <= 1'b0;
            if (axi_rsp.rvalid === 1'b1) begin
                resp = axi_rsp.rresp;
                chk(what, exp, axi_rsp.rdata);
                break;
            end
        end
    endtask

    // always lets one edge pass, so a driver never assigns twice at once
    task automatic wait_for(input int sel, input logic lvl, input int lim,
                            output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (n < lim && mon[sel] !== lvl);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("code", 32'h0, 32'(pullup_strength_code));
        rd(ADDR_RISE, 32'(RISE_RST), "rise");
        rd(ADDR_FALL, 32'(FALL_RST), "fall");
        wr(8'h20, 32'h3);
        chk("bresp", 32'(RESP_ERR), 32'(resp));
        rd(8'h20, 32'h0, "unmapped");
        chk("rresp", 32'(RESP_ERR), 32'(resp));
        rd(ADDR_MODE, 32'h0, "mode");
        wr(ADDR_PUCFG, 32'h11);
        chk("sw code", 32'h11, 32'(pullup_strength_code));
        $display("test reset finished");
    endtask

    task automatic t_modes();
        int n;
        int p;
        wr(ADDR_RISE, 32'h2);
        wr(ADDR_FALL, 32'h1);
        for (int m = 0; m < 4; m++) begin
            p = 80 << m;
            wr(ADDR_MODE, 32'(m));
            closed_a <= 1'b1;
            wait_for(0, 1'b0, 3 * p, n);
            closed_a <= 1'b0;
            wait_for(0, 1'b1, 3 * p, n);
            chk("rise delay", 1, 32'(n >= p - 2 && n <= 2 * p + 20));
        end
        rd(ADDR_STATE, 32'h5, "state");
        chk("counter b", 0, 32'(counter_in_b));
        $display("test modes finished");
    endtask

    task automatic t_noise();
        int n;
        wr(ADDR_MODE, 32'h0);
        wr(ADDR_RISE, 32'h3);
        wr(ADDR_FALL, 32'h3);
        closed_a <= 1'b1;
        repeat (100) @(posedge clk);
        closed_a <= 1'b0;
        wait_for(0, 1'b0, 800, n);
        chk("glitch held", 32'd800, 32'(n));
        closed_a <= 1'b1;
        wait_for(0, 1'b0, 400, n);
        chk("fall delay", 1, 32'(n >= 158 && n <= 260));
        $display("test noise finished");
    endtask

    task automatic t_flag();
        int n;
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_STS, 32'h7);
        wr(ADDR_MSK, 32'h1);
        closed_a <= 1'b0;
        wait_for(3, 1'b1, 300, n);
        chk("irq open", 1, 32'(irq));
        rd(ADDR_STS, 32'h1, "sts open");
        wr(ADDR_STS, 32'h1);
        rd(ADDR_STS, 32'h0, "sts w1c");
        chk("irq clear", 0, 32'(irq));
        $display("test flag finished");
    endtask

    task automatic t_cal_ok();
        int   n;
        logic hold_a;
        logic frozen;
        need_b   <= 5'd5;
        closed_b <= 1'b0;
        wr(ADDR_CTRL, 32'h2);
        wr(ADDR_STS, 32'h7);
        wr(ADDR_MSK, 32'h2);
        wr(ADDR_CTRL, 32'h3);
        hold_a = counter_in_a;
        frozen = 1'b1;
        n = 0;
        // input a bounces throughout; its counter output must not move
        while (count_hold === 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
            if (n % 50 == 0)
                closed_a <= !closed_a;
            if (counter_in_a !== hold_a)
                frozen = 1'b0;
        end
        chk("frozen", 1, 32'(frozen));
        chk("cal time", 1, 32'(n >= 1355 && n <= 1460));
        chk("code", 32'd5, 32'(pullup_strength_code));
        rd(ADDR_PUCFG, 32'h5, "pucfg");
        rd(ADDR_STS, 32'h3, "sts done");
        chk("irq done", 1, 32'(irq));
        wait_for(1, 1'b1, 400, n);
        chk("counter b up", 1, 32'(counter_in_b));
        $display("test calibration pass finished");
    endtask

    task automatic t_cal_fail();
        int n;
        closed_b <= 1'b1;
        wr(ADDR_STS, 32'h7);
        wr(ADDR_CTRL, 32'h3);
        wait_for(2, 1'b0, 8000, n);
        chk("fail time", 1, 32'(n >= 6630 && n <= 6740));
        chk("code", 32'd27, 32'(pullup_strength_code));
        rd(ADDR_PUCFG, 32'h5B, "pucfg");
        rd(ADDR_STS, 32'h6, "sts fail");
        $display("test calibration fail finished");
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        n_fail = 0;
        cmp_count = 0;
        axi_req = '0;
        axi_req.bready = 1'b1;
        axi_req.rready = 1'b1;
        sys_rst = 1'b1;
        closed_a = 1'b1;
        closed_b = 1'b1;
        need_a = 5'd0;
        need_b = 5'd0;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_modes();
        t_noise();
        t_flag();
        t_cal_ok();
        t_cal_fail();
        end_of_test();
    end

endmodule
